// ---- logic/vfc_cfg.svh ----
// Constants for the video input format, clamp and sync control block
// Overview of operation
// - Component mode puts chroma black at 0x80
// - Component mode only when 0x10 bit4 set
// - No colour conversion; RGB samples pass unchanged
// - 4:4:4 maps luma green, Cb blue, Cr red
// - 4:2:2: blue low, red alternates even chroma
// - AC coupling default, DC via 0x10 bit3
// - AC mode clamps once every line
// - Clamp suppressed while loop coasts, unless enabled
// - Clamp starts when pixel count reaches start
// - Clamp lasts exactly width pixels per line
// - Green sync threshold 4-bit, hysteresis, filter registers
// - Three sync sources with activity detection
// - Protection mask ANDed on green composite sync
// - Mask gates hsync output unless disable bit
// - Gain 0x4C gives full phase gain
// - Midscale follows mode unless override bit set
`ifndef VFC_CFG_SVH
`define VFC_CFG_SVH
`define VFC_A_USER      8'h10
`define VFC_A_START_HI  8'h24
`define VFC_A_START_LO  8'h25
`define VFC_A_WIDTH     8'h26
`define VFC_A_OUTFMT    8'h28
`define VFC_A_GS_THR    8'h30
`define VFC_A_GS_CFG    8'h31
`define VFC_A_MID       8'h60
`define VFC_A_GAIN      8'h74
`define VFC_A_MASK      8'h7A
`define VFC_A_STATUS    8'h7F
`define VFC_B_DC        3
`define VFC_B_YUV       4
`define VFC_B_422       0
`define VFC_B_COASTCLP  2
`define VFC_B_MIDOVR    7
`define VFC_B_MID_B     4
`define VFC_B_MID_G     5
`define VFC_B_MID_R     6
`define VFC_B_MASKDIS   4
`define VFC_R_USER      8'h00
`define VFC_R_START     16'h0000
`define VFC_R_WIDTH     8'h08
`define VFC_R_GS_THR    8'h00
`define VFC_R_MID       8'h00
`define VFC_R_GAIN      8'h49
`define VFC_GAIN_TAPE   8'h4C
`define VFC_MIDSCALE    8'h80
`define VFC_ZERO8       8'h00
`define VFC_ACT_LIMIT   16'hFFFF
`define VFC_FIFO_DEPTH  4
`define VFC_FIFO_WIDTH  24
`endif

// ---- logic/vfc_fifo.sv ----
// Small flip-flop FIFO for output pixel words
`timescale 1ns/1ps
module vfc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vfc_fifo

// ---- logic/vfc_pkg.sv ----
// Types for the video input format, clamp and sync control block
package vfc_pkg;
    typedef enum logic [1:0] {
        VFC_IDLE  = 2'b00,
        VFC_WAIT  = 2'b01,
        VFC_CLAMP = 2'b10,
        VFC_DONE  = 2'b11
    } vfc_clamp_type;
endpackage

// ---- logic/vfc_top.sv ----
// Video input format, clamp timing and sync control
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "vfc_cfg.svh"
module vfc_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Digitized samples, one per pixel clock
    input  wire logic [7:0]  adc_red,
    input  wire logic [7:0]  adc_green,
    input  wire logic [7:0]  adc_blue,
    input  wire logic        pix_valid,
    // Sync inputs (pins)
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic        green_embedded_sync,
    input  wire logic        loop_coasting,
    input  wire logic        protect_detect,
    // Pixel output stream
    output logic      [7:0]  out_red,
    output logic      [7:0]  out_green,
    output logic      [7:0]  out_blue,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic             in_ready,
    // Analog side controls
    output logic             clamp_on,
    output logic             dc_coupled,
    output logic      [2:0]  midscale_en,
    output logic      [3:0]  gs_threshold,
    output logic      [7:0]  gs_config,
    output logic      [7:0]  loop_gain,
    output logic             loop_sync,
    output logic             hsync_out
);
    logic [1:0] rs_q;
    logic       rst_int_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_q <= 2'b00;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_int_n = rs_q[1];

    // Registers
    logic [7:0]  user_q;
    logic [15:0] start_q;
    logic [7:0]  width_q;
    logic [7:0]  outfmt_q;
    logic [7:0]  gs_thr_q;
    logic [7:0]  gs_cfg_q;
    logic [7:0]  mid_q;
    logic [7:0]  gain_q;
    logic [7:0]  mask_q;
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            user_q    <= `VFC_R_USER;
            start_q   <= `VFC_R_START;
            width_q   <= `VFC_R_WIDTH;
            outfmt_q  <= `VFC_ZERO8;
            gs_thr_q  <= `VFC_R_GS_THR;
            gs_cfg_q  <= `VFC_ZERO8;
            mid_q     <= `VFC_R_MID;
            gain_q    <= `VFC_R_GAIN;
            mask_q    <= `VFC_ZERO8;
        end else if (reg_wr) begin
            case (reg_addr)
                `VFC_A_USER:     user_q        <= reg_wdata;
                `VFC_A_START_HI: start_q[15:8] <= reg_wdata;
                `VFC_A_START_LO: start_q[7:0]  <= reg_wdata;
                `VFC_A_WIDTH:    width_q       <= reg_wdata;
                `VFC_A_OUTFMT:   outfmt_q      <= reg_wdata;
                `VFC_A_GS_THR:   gs_thr_q      <= reg_wdata;
                `VFC_A_GS_CFG:   gs_cfg_q      <= reg_wdata;
                `VFC_A_MID:      mid_q         <= reg_wdata;
                `VFC_A_GAIN:     gain_q        <= reg_wdata;
                `VFC_A_MASK:     mask_q        <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Pin synchronisers: change accepted once stages two and three agree
    logic [2:0] sy0_q, sy1_q, sy2_q, sy3_q, sy4_q;
    logic [4:0] pin_q;
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            sy0_q <= 3'h0;
            sy1_q <= 3'h0;
            sy2_q <= 3'h0;
            sy3_q <= 3'h0;
            sy4_q <= 3'h0;
            pin_q <= 5'h00;
        end else begin
            sy0_q <= {sy0_q[1:0], hsync_in};
            sy1_q <= {sy1_q[1:0], vsync_in};
            sy2_q <= {sy2_q[1:0], green_embedded_sync};
            sy3_q <= {sy3_q[1:0], loop_coasting};
            sy4_q <= {sy4_q[1:0], protect_detect};
            if (sy0_q[1] == sy0_q[2]) pin_q[0] <= sy0_q[2];
            if (sy1_q[1] == sy1_q[2]) pin_q[1] <= sy1_q[2];
            if (sy2_q[1] == sy2_q[2]) pin_q[2] <= sy2_q[2];
            if (sy3_q[1] == sy3_q[2]) pin_q[3] <= sy3_q[2];
            if (sy4_q[1] == sy4_q[2]) pin_q[4] <= sy4_q[2];
        end
    end
    logic hs_s, vs_s, gs_s, coast_s, prot_s;
    assign {prot_s, coast_s, gs_s, vs_s, hs_s} = pin_q;

    // Copy-protection mask on the composite sync paths
    logic sync_mask;
    assign sync_mask = ~prot_s;
    assign loop_sync = gs_s & sync_mask;
    logic hs_prev_q, hsync_out_q;
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            hsync_out_q <= 1'b0;
        end else begin
            hsync_out_q <= mask_q[`VFC_B_MASKDIS] ? hs_s
                                                  : (hs_s & sync_mask);
        end
    end
    assign hsync_out = hsync_out_q;

    // Activity detection per sync source, cleared by read of status
    logic [2:0] act_q;
    logic [2:0] prev_q;
    logic       stat_rd;
    assign stat_rd = reg_rd && (reg_addr == `VFC_A_STATUS);
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            act_q  <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            prev_q <= {gs_s, vs_s, hs_s};
            // Set beats clear so no edge is lost at the read
            act_q <= (stat_rd ? 3'h0 : act_q)
                   | ({gs_s, vs_s, hs_s} ^ prev_q);
        end
    end

    // Clamp timing
    vfc_pkg::vfc_clamp_type st_q;
    logic [15:0] pix_q;
    logic        hs_fall;
    logic        coast_line_q;
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            hs_prev_q <= 1'b0;
        end else begin
            hs_prev_q <= hs_s;
        end
    end
    assign hs_fall = hs_prev_q & ~hs_s;

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            coast_line_q <= 1'b0;
        end else if (hs_fall) begin
            coast_line_q <= coast_s;
        end else if (coast_s) begin
            coast_line_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            st_q  <= vfc_pkg::VFC_IDLE;
            pix_q <= 16'h0000;
        end else if (hs_fall) begin
            st_q  <= vfc_pkg::VFC_WAIT;
            pix_q <= 16'h0000;
        end else begin
            pix_q <= pix_q + 16'h0001;
            case (st_q)
                vfc_pkg::VFC_WAIT: begin
                    if (pix_q == start_q) begin
                        st_q  <= (width_q == `VFC_ZERO8)
                                 ? vfc_pkg::VFC_DONE : vfc_pkg::VFC_CLAMP;
                        pix_q <= 16'h0000;
                    end
                end
                vfc_pkg::VFC_CLAMP: begin
                    if (pix_q[7:0] == width_q - 8'h01) begin
                        st_q <= vfc_pkg::VFC_DONE;
                    end
                end
                vfc_pkg::VFC_DONE: pix_q <= pix_q;
                vfc_pkg::VFC_IDLE: pix_q <= pix_q;
                default: st_q <= vfc_pkg::VFC_IDLE;
            endcase
        end
    end
    logic clamp_allow;
    assign clamp_allow = ~user_q[`VFC_B_DC]
                       & (mid_q[`VFC_B_COASTCLP] | ~coast_line_q);
    assign clamp_on    = (st_q == vfc_pkg::VFC_CLAMP) & clamp_allow;

    // Format mapping
    logic yuv;
    logic [2:0] mid_sel;
    assign yuv = user_q[`VFC_B_YUV];
    assign dc_coupled = user_q[`VFC_B_DC];
    // Bits are {red, green, blue}; a zero in the red or blue bit adds the half-scale shift
    assign mid_sel = mid_q[`VFC_B_MIDOVR]
        ? {mid_q[`VFC_B_MID_R], mid_q[`VFC_B_MID_G], mid_q[`VFC_B_MID_B]}
        : {~yuv, 1'b1, ~yuv};
    assign midscale_en   = mid_sel;
    assign gs_threshold  = gs_thr_q[3:0];
    assign gs_config     = gs_cfg_q;
    assign loop_gain     = gain_q;

    // Chroma black sits at mid scale: signed samples shifted up
    logic [7:0] red_c, blue_c;
    assign red_c  = mid_sel[2] ? adc_red  : adc_red  ^ `VFC_MIDSCALE;
    assign blue_c = mid_sel[0] ? adc_blue : adc_blue ^ `VFC_MIDSCALE;

    logic       odd_q;
    logic [7:0] cr_hold_q;
    logic       f_ready;
    logic [23:0] word;
    logic       dec;
    assign dec = yuv & outfmt_q[`VFC_B_422];
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            odd_q     <= 1'b0;
            cr_hold_q <= `VFC_ZERO8;
        end else if (hs_fall) begin
            odd_q <= 1'b0;
        end else if (pix_valid && f_ready) begin
            odd_q <= ~odd_q;
            if (!odd_q) cr_hold_q <= red_c;
        end
    end
    // No colour conversion: 4:4:4 words pass channel for channel
    always_comb begin
        word = {red_c, adc_green, blue_c};
        if (dec) begin
            word = {odd_q ? cr_hold_q : blue_c, adc_green, `VFC_ZERO8};
        end
    end

    logic [23:0] f_data;
    vfc_fifo #(
        .WIDTH(`VFC_FIFO_WIDTH),
        .DEPTH(`VFC_FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_int_n),
        .in_valid  (pix_valid),
        .in_ready  (f_ready),
        .in_data   (word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (f_data)
    );
    assign in_ready = f_ready;
    assign {out_red, out_green, out_blue} = f_data;

    // Register read, data one cycle later
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            reg_rdata <= `VFC_ZERO8;
        end else if (reg_rd) begin
            case (reg_addr)
                `VFC_A_USER:     reg_rdata <= user_q;
                `VFC_A_START_HI: reg_rdata <= start_q[15:8];
                `VFC_A_START_LO: reg_rdata <= start_q[7:0];
                `VFC_A_WIDTH:    reg_rdata <= width_q;
                `VFC_A_OUTFMT:   reg_rdata <= outfmt_q;
                `VFC_A_GS_THR:   reg_rdata <= gs_thr_q;
                `VFC_A_GS_CFG:   reg_rdata <= gs_cfg_q;
                `VFC_A_MID:      reg_rdata <= mid_q;
                `VFC_A_GAIN:     reg_rdata <= gain_q;
                `VFC_A_MASK:     reg_rdata <= mask_q;
                `VFC_A_STATUS:   reg_rdata <= {3'h0, coast_s, prot_s, act_q};
                default:         reg_rdata <= `VFC_ZERO8;
            endcase
        end else begin
            reg_rdata <= `VFC_ZERO8;
        end
    end

    // Checks
    AST_CLAMP_DC_OFF: assert property (@(posedge core_clk)
        disable iff (!rst_int_n) dc_coupled |-> !clamp_on)
        else $error("clamp active in dc mode");
    AST_COAST_SUPPRESS: assert property (@(posedge core_clk)
        disable iff (!rst_int_n)
        (coast_line_q && !mid_q[`VFC_B_COASTCLP]) |-> !clamp_on)
        else $error("clamp during coast");
    AST_CLAMP_START: assert property (@(posedge core_clk)
        disable iff (!rst_int_n)
        (st_q == vfc_pkg::VFC_WAIT && pix_q == start_q && !hs_fall
         && width_q != `VFC_ZERO8)
        |=> st_q == vfc_pkg::VFC_CLAMP)
        else $error("clamp did not start");
    AST_CLAMP_END: assert property (@(posedge core_clk)
        disable iff (!rst_int_n)
        (st_q == vfc_pkg::VFC_CLAMP && pix_q[7:0] == width_q - 8'h01
         && !hs_fall) |=> st_q == vfc_pkg::VFC_DONE)
        else $error("clamp width wrong");
    AST_RESTART: assert property (@(posedge core_clk)
        disable iff (!rst_int_n)
        hs_fall |=> (pix_q == 16'h0000 && st_q == vfc_pkg::VFC_WAIT))
        else $error("counter not restarted");

    AST_HS_MASK: assert property (@(posedge core_clk)
        disable iff (!rst_int_n)
        (prot_s && !mask_q[`VFC_B_MASKDIS]) |=> !hsync_out)
        else $error("hsync not masked");
    AST_LOOP_MASK: assert property (@(posedge core_clk)
        disable iff (!rst_int_n) prot_s |-> !loop_sync)
        else $error("loop sync not masked");
    AST_422_BLUE: assert property (@(posedge core_clk)
        disable iff (!rst_int_n) dec |-> word[7:0] == `VFC_ZERO8)
        else $error("blue not low in 4:2:2");
    AST_MID_CHROMA: assert property (@(posedge core_clk)
        disable iff (!rst_int_n)
        (yuv && !mid_q[`VFC_B_MIDOVR] && !dec)
        |-> word[7:0] == (adc_blue ^ `VFC_MIDSCALE))
        else $error("chroma black not mid scale");
    AST_GAIN_LOAD: assert property (@(posedge core_clk)
        disable iff (!rst_int_n) (reg_wr && reg_addr == `VFC_A_GAIN)
        |=> loop_gain == $past(reg_wdata))
        else $error("loop gain not loaded");
    AST_ACT_SET: assert property (@(posedge core_clk)
        disable iff (!rst_int_n) (hs_s != prev_q[0]) |=> act_q[0])
        else $error("hsync activity missed");

    COV_CLAMP: cover property (@(posedge core_clk) clamp_on);
    COV_422: cover property (@(posedge core_clk) dec && pix_valid);
    COV_FULL: cover property (@(posedge core_clk) !f_ready);
    COV_COAST: cover property (@(posedge core_clk) hs_fall && coast_line_q);
endmodule // vfc_top

// ---- tb/tb.sv ----
// Self-checking bench for the video format, clamp and sync block
`timescale 1ns/1ps
`include "vfc_cfg.svh"
module tb;
    localparam int LINE = 100;
    localparam int HS_W = 8;
    logic        core_clk = 1'b0, rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, vsync_in = 1'b0;
    logic        green_embedded_sync = 1'b0, loop_coasting = 1'b0;
    logic        protect_detect = 1'b0, lines_on = 1'b0, feed_on = 1'b0;
    logic [1:0]  sink_mode = 2'd0;
    logic [7:0]  reg_rdata, adc_red, adc_green, adc_blue;
    logic [7:0]  out_red, out_green, out_blue, loop_gain, gs_config;
    logic        pix_valid, hsync_in, out_valid, out_ready, in_ready;
    logic        clamp_on, dc_coupled, loop_sync, hsync_out;
    logic [2:0]  midscale_en;
    logic [3:0]  gs_threshold;
    int          n_fail = 0, tests_run = 0, n_push = 0;
    logic        yuv = 1'b0, f422 = 1'b0, par = 1'b0;
    logic [7:0]  cr_q = 8'h00;
    logic [23:0] exp_q[$];

    always #20 core_clk = ~core_clk;

    vfc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adc_red(adc_red), .adc_green(adc_green),
        .adc_blue(adc_blue), .pix_valid(pix_valid), .hsync_in(hsync_in),
        .vsync_in(vsync_in), .green_embedded_sync(green_embedded_sync),
        .loop_coasting(loop_coasting), .protect_detect(protect_detect),
        .out_red(out_red), .out_green(out_green), .out_blue(out_blue),
        .out_valid(out_valid), .out_ready(out_ready), .in_ready(in_ready),
        .clamp_on(clamp_on), .dc_coupled(dc_coupled),
        .midscale_en(midscale_en), .gs_threshold(gs_threshold),
        .gs_config(gs_config), .loop_gain(loop_gain),
        .loop_sync(loop_sync), .hsync_out(hsync_out));

    vfc_src_model #(.LINE(LINE), .HS_W(HS_W)) src (.core_clk(core_clk),
        .lines_on(lines_on), .feed_on(feed_on), .sink_mode(sink_mode),
        .in_ready(in_ready), .hsync_in(hsync_in), .adc_red(adc_red),
        .adc_green(adc_green), .adc_blue(adc_blue), .pix_valid(pix_valid),
        .out_ready(out_ready));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0h expected %0h",
                     $time, what, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                       input string what);
        logic [7:0] d;
        rd(a, d);
        chk({24'h0, d}, {24'h0, e}, what);
    endtask

    // Any window of one line length holds exactly one period
    task automatic scan(output int dly, output int wid, output int npul,
                        output int nhs);
        logic prev;
        dly = -1; wid = 0; npul = 0; nhs = 0;
        @(negedge hsync_in);
        prev = clamp_on;
        for (int t = 0; t < LINE; t++) begin
            wait_cyc(1);
            if (clamp_on && !prev) npul++;
            if (clamp_on && !prev && dly < 0) dly = t;
            if (clamp_on) wid++;
            if (hsync_out) nhs++;
            prev = clamp_on;
        end
    endtask

    task automatic stream(input logic y, input logic f,
                          input logic [1:0] sm, input int n);
        yuv = y;
        f422 = f;
        wr(`VFC_A_USER, {3'b000, y, 4'h0});
        wr(`VFC_A_OUTFMT, {7'h00, f});
        lines_on <= 1'b1;
        wait_cyc(LINE);
        lines_on <= 1'b0;
        wait_cyc(HS_W + 10);
        par = 1'b0;
        n_push = 0;
        sink_mode <= sm;
        feed_on <= 1'b1;
        for (int t = 0; t < 2000 && n_push < n; t++) wait_cyc(1);
        feed_on <= 1'b0;
        for (int t = 0; t < 2000 && exp_q.size() != 0; t++) wait_cyc(1);
        chk(exp_q.size(), 0, "words left in buffer");
    endtask

    // Scoreboard sampled mid-cycle where handshakes are settled
    always @(negedge core_clk) begin
        if (rst_n && pix_valid && in_ready) begin
            n_push++;
            if (!yuv)
                exp_q.push_back({adc_red, adc_green, adc_blue});
            else if (!f422)
                exp_q.push_back({adc_red ^ 8'h80, adc_green,
                                 adc_blue ^ 8'h80});
            else if (!par) begin
                exp_q.push_back({adc_blue ^ 8'h80, adc_green, 8'h00});
                cr_q = adc_red ^ 8'h80;
            end else
                exp_q.push_back({cr_q, adc_green, 8'h00});
            par = !par;
        end
        if (rst_n && out_valid && out_ready) begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0, "unexpected word");
            else
                chk({8'h00, out_red, out_green, out_blue}, {8'h00, exp_q.pop_front()}, "pixel word");
        end
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        n_fail++;
        $display("wrong value at %0t: run did not finish", $time);
        wrap_up();
    end

    initial begin
        logic [7:0] d;
        int dly0, dly1, wid, np, nhs;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_cyc(3);
        rdc(`VFC_A_GAIN, `VFC_R_GAIN, "gain at reset");
        rdc(`VFC_A_WIDTH, `VFC_R_WIDTH, "width at reset");
        rdc(`VFC_A_USER, `VFC_R_USER, "user at reset");
        rdc(8'h55, 8'h00, "unmapped read");
        chk(dc_coupled, 0, "coupling at reset");
        wr(8'h55, 8'hFF);
        wr(`VFC_A_USER, 8'h08);
        wait_cyc(1);
        chk(dc_coupled, 1, "dc coupling");
        wr(`VFC_A_GAIN, `VFC_GAIN_TAPE);
        wait_cyc(1);
        chk(loop_gain, 32'h4C, "tape gain");
        wr(`VFC_A_GAIN, `VFC_R_GAIN);
        wr(`VFC_A_GS_THR, 8'h0F);
        wr(`VFC_A_GS_CFG, 8'hA5);
        wait_cyc(1);
        chk(gs_threshold, 32'hF, "green threshold");
        chk(gs_config, 32'hA5, "green config");
        // Clamp timing in AC mode
        wr(`VFC_A_USER, 8'h00);
        wait_cyc(1);
        chk(midscale_en, 32'h7, "rgb midscale");
        wr(`VFC_A_START_HI, 8'h00);
        wr(`VFC_A_START_LO, 8'h05);
        wr(`VFC_A_WIDTH, 8'h03);
        lines_on <= 1'b1;
        wait_cyc(LINE);
        scan(dly0, wid, np, nhs);
        chk(wid, 3, "clamp width");
        chk(np, 1, "clamps per line");
        chk(nhs, HS_W, "hsync out unmasked");
        green_embedded_sync <= 1'b1;
        wr(`VFC_A_START_LO, 8'h35);
        wait_cyc(LINE);
        scan(dly1, wid, np, nhs);
        chk(dly1 - dly0, 32'h30, "clamp start shift");
        loop_coasting <= 1'b1;
        wait_cyc(LINE);
        scan(dly1, wid, np, nhs);
        chk(np, 0, "clamp while coasting");
        wr(`VFC_A_MID, 8'h04);
        wait_cyc(LINE);
        scan(dly1, wid, np, nhs);
        chk(np, 1, "clamp allowed coasting");
        loop_coasting <= 1'b0;
        wr(`VFC_A_MID, 8'h00);
        chk(loop_sync, 1, "green sync to loop");
        protect_detect <= 1'b1;
        wait_cyc(LINE);
        scan(dly1, wid, np, nhs);
        chk(loop_sync, 0, "loop sync masked");
        chk(nhs, 0, "hsync out masked");
        wr(`VFC_A_MASK, 8'h10);
        wait_cyc(LINE);
        scan(dly1, wid, np, nhs);
        chk(nhs, HS_W, "mask disabled");
        protect_detect <= 1'b0;
        wr(`VFC_A_MASK, 8'h00);
        // Activity detection, one source at a time
        lines_on <= 1'b0;
        green_embedded_sync <= 1'b0;
        wait_cyc(20);
        rd(`VFC_A_STATUS, d);
        rdc(`VFC_A_STATUS, 8'h00, "activity cleared");
        vsync_in <= 1'b1;
        wait_cyc(10);
        vsync_in <= 1'b0;
        wait_cyc(10);
        rdc(`VFC_A_STATUS, 8'h02, "vsync activity");
        green_embedded_sync <= 1'b1;
        wait_cyc(10);
        green_embedded_sync <= 1'b0;
        wait_cyc(10);
        rdc(`VFC_A_STATUS, 8'h04, "green activity");
        lines_on <= 1'b1;
        wait_cyc(LINE);
        lines_on <= 1'b0;
        wait_cyc(20);
        rdc(`VFC_A_STATUS, 8'h01, "hsync activity");
        // Midscale selection
        wr(`VFC_A_USER, 8'h10);
        wait_cyc(1);
        chk(midscale_en, 32'h2, "component midscale");
        wr(`VFC_A_MID, 8'hD0);
        wait_cyc(1);
        chk(midscale_en, 32'h5, "override midscale");
        wr(`VFC_A_MID, 8'hA0);
        wait_cyc(1);
        chk(midscale_en, 32'h2, "override midscale");
        wr(`VFC_A_MID, 8'h00);
        // Pixel stream in each format
        stream(1'b0, 1'b0, 2'd0, 12);
        stream(1'b1, 1'b0, 2'd1, 12);
        stream(1'b1, 1'b1, 2'd1, 13);
        // Buffer fills to its depth while the sink stalls
        sink_mode <= 2'd2;
        n_push = 0;
        feed_on <= 1'b1;
        wait_cyc(20);
        chk(n_push, `VFC_FIFO_DEPTH, "buffer depth");
        chk(in_ready, 0, "full buffer refuses");
        feed_on <= 1'b0;
        sink_mode <= 2'd1;
        for (int t = 0; t < 500 && exp_q.size() != 0; t++) wait_cyc(1);
        chk(exp_q.size(), 0, "buffer drained");
        wait_cyc(4);
        chk(out_valid, 0, "empty buffer");
        wrap_up();
    end
endmodule // tb

// ---- tb/vfc_src_model.sv ----
// Video source and downstream sink model for the format block
`timescale 1ns/1ps
module vfc_src_model #(
    parameter int LINE = 100,
    parameter int HS_W = 8
) (
    // Clock
    input  wire logic       core_clk,
    // Bench controls
    input  wire logic       lines_on,
    input  wire logic       feed_on,
    input  wire logic [1:0] sink_mode,
    // Source side
    input  wire logic       in_ready,
    output logic            hsync_in,
    output logic      [7:0] adc_red,
    output logic      [7:0] adc_green,
    output logic      [7:0] adc_blue,
    output logic            pix_valid,
    // Sink side
    output logic            out_ready
);
    int         pos_q  = 0;
    logic [7:0] k_q    = 8'h00;
    logic [1:0] slow_q = 2'b00;

    initial begin
        hsync_in  = 1'b0;
        pix_valid = 1'b0;
        out_ready = 1'b0;
        adc_red   = 8'h00;
        adc_green = 8'h00;
        adc_blue  = 8'h00;
    end

    // Sync pulse is high, so the trailing edge is the fall
    always @(posedge core_clk) begin
        pos_q    <= (pos_q == LINE - 1) ? 0 : pos_q + 1;
        hsync_in <= lines_on && (pos_q < HS_W);
    end

    // Sample held until taken; idle data toggles so nothing stale passes
    always @(posedge core_clk) begin
        if (!pix_valid || in_ready) begin
            pix_valid <= feed_on;
            k_q       <= k_q + (feed_on ? 8'h01 : 8'h00);
            adc_red   <= feed_on ? k_q * 8'h07 + 8'h03 : ~adc_red;
            adc_green <= feed_on ? k_q + 8'h40 : ~adc_green;
            adc_blue  <= feed_on ? k_q * 8'h0D + 8'h81 : ~adc_blue;
        end
    end

    // Mode 0 prompt, 1 one cycle in four, 2 stalled
    always @(posedge core_clk) begin
        slow_q    <= slow_q + 2'b01;
        out_ready <= (sink_mode == 2'd0) ||
                     (sink_mode == 2'd1 && slow_q == 2'b00);
    end
endmodule // vfc_src_model
